// >>> src/apc_config_reg.sv
`timescale 1ns/1ps
`default_nettype none
module apc_config_reg
    import apc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic reset_func,
    input wire logic feedthrough_pin_n,
    input wire logic serial_powerup_cmd,
    input wire logic powerdown_cmd,
    input wire logic load_cmd,
    input wire logic [11:0] load_data,
    input wire logic store_cmd,
    input wire logic [1:0] op,
    input wire logic ranged_play_cmd,
    output logic [11:0] analog_path_config,
    output logic [11:0] nonvol_config_bits,
    output logic serial_mode,
    output logic [2:0] volume_step,
    output logic effect_edit_enable,
    output logic current_out_en,
    output logic aux_out_en,
    output logic speaker_driver_en,
    output logic analog_out_power_on,
    output logic low_voltage_alert_en,
    output logic end_marker_stop,
    output logic ranged_stop_at_marker,
    output logic rec_from_mic,
    output logic rec_from_aux,
    output logic ft_mic_to_out,
    output logic ft_aux_to_out,
    output logic play_stored,
    output logic play_aux_mix
);
    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    logic ft_meta_q;
    logic ft_sync_q;
    logic ft_meta_d;
    logic ft_sync_d;

    always_comb begin
        ft_meta_d = feedthrough_pin_n;
        ft_sync_d = ft_meta_q;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ft_meta_q <= 1'b1;
            ft_sync_q <= 1'b1;
        end else begin
            ft_meta_q <= ft_meta_d;
            ft_sync_q <= ft_sync_d;
        end
    end

    // ------------------------------------------------------------------
    // Nonvolatile bits and working register
    // ------------------------------------------------------------------
    logic [11:0] nv_q;
    logic [11:0] nv_d;
    logic [11:0] apc_q;
    logic [11:0] apc_d;
    logic reload_q;
    logic reload_d;

    always_comb begin
        nv_d = nv_q;
        if (store_cmd) begin
            nv_d = apc_q;
        end
        // Reload one cycle after reset release, so the register takes the stored bits
        reload_d = 1'b0;
        apc_d = apc_q;
        if (reload_q || reset_func) begin
            apc_d = nv_q;
        end else if (load_cmd) begin
            apc_d = load_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nv_q <= APC_FACTORY_DEFAULT;
            apc_q <= APC_FACTORY_DEFAULT;
            reload_q <= 1'b1;
        end else begin
            nv_q <= nv_d;
            apc_q <= apc_d;
            reload_q <= reload_d;
        end
    end

    // ------------------------------------------------------------------
    // Serial mode tracker
    // ------------------------------------------------------------------
    apc_mode_t mode_q;
    apc_mode_t mode_d;

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            APC_ST_STANDALONE: begin
                if (serial_powerup_cmd) begin
                    mode_d = APC_ST_SERIAL;
                end
            end
            APC_ST_SERIAL: begin
                if (powerdown_cmd) begin
                    mode_d = APC_ST_STANDALONE;
                end
            end
            default: begin
                mode_d = APC_ST_STANDALONE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= APC_ST_STANDALONE;
        end else begin
            mode_q <= mode_d;
        end
    end

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    logic ft_ctrl;
    logic ft_ctrl_on;

    always_comb begin
        // Control value 0 means feed-through on, for both pin and bit 6
        ft_ctrl = (mode_q == APC_ST_SERIAL) ? apc_q[BIT_SER_FT_OFF] : ft_sync_q;
        ft_ctrl_on = !ft_ctrl;
    end

    assign analog_path_config = apc_q;
    assign nonvol_config_bits = nv_q;
    assign serial_mode = (mode_q == APC_ST_SERIAL);
    assign volume_step = apc_q[VOL_LSB +: VOL_W];
    assign effect_edit_enable = !apc_q[BIT_EDIT_DIS] && (mode_q == APC_ST_STANDALONE);
    assign current_out_en = !apc_q[BIT_AOUT_OFF] && !apc_q[BIT_OUT_TYPE];
    assign aux_out_en = !apc_q[BIT_AOUT_OFF] && apc_q[BIT_OUT_TYPE];
    assign speaker_driver_en = !apc_q[BIT_SPK_DIS];
    assign analog_out_power_on = !apc_q[BIT_AOUT_OFF];
    assign low_voltage_alert_en = !apc_q[BIT_LVA_OFF];
    assign end_marker_stop = apc_q[BIT_EOM_STOP];
    assign ranged_stop_at_marker = ranged_play_cmd && apc_q[BIT_EOM_STOP];

    apc_path_decode u_decode (
        .monitor_en(apc_q[BIT_MONITOR]),
        .mix_en(apc_q[BIT_MIX]),
        .ft_on(ft_ctrl_on),
        .op(op),
        .rec_from_mic(rec_from_mic),
        .rec_from_aux(rec_from_aux),
        .ft_mic_to_out(ft_mic_to_out),
        .ft_aux_to_out(ft_aux_to_out),
        .play_stored(play_stored),
        .play_aux_mix(play_aux_mix)
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_reset_default: assert property (@(posedge clk)
        $rose(resetn) |-> apc_q == APC_FACTORY_DEFAULT)
        else $error("register not at default after reset");
    a_nv_default: assert property (@(posedge clk)
        $rose(resetn) |-> nv_q == APC_FACTORY_DEFAULT)
        else $error("stored bits not at default after reset");
    a_reload_start: assert property (@(posedge clk) disable iff (!resetn)
        reload_q |=> apc_q == $past(nv_q))
        else $error("register not reloaded after reset");
    a_reload_once: assert property (@(posedge clk) disable iff (!resetn)
        reload_q |=> !reload_q)
        else $error("post-reset reload repeated");
    a_func_reload: assert property (@(posedge clk) disable iff (!resetn)
        reset_func |=> apc_q == $past(nv_q))
        else $error("reset function did not reload");
    a_load_takes: assert property (@(posedge clk) disable iff (!resetn)
        load_cmd && !reset_func && !reload_q |=> apc_q == $past(load_data))
        else $error("load not taken");
    a_load_refused: assert property (@(posedge clk) disable iff (!resetn)
        load_cmd && (reset_func || reload_q) |=> apc_q == $past(nv_q))
        else $error("load not overridden by reload");
    a_reg_holds: assert property (@(posedge clk) disable iff (!resetn)
        !load_cmd && !reset_func && !reload_q |=> apc_q == $past(apc_q))
        else $error("register changed without command");
    a_store_copies: assert property (@(posedge clk) disable iff (!resetn)
        store_cmd |=> nv_q == $past(apc_q))
        else $error("store did not copy");
    a_nv_holds: assert property (@(posedge clk) disable iff (!resetn)
        !store_cmd |=> nv_q == $past(nv_q))
        else $error("stored bits changed without store");

    a_serial_enter: assert property (@(posedge clk) disable iff (!resetn)
        !serial_mode && serial_powerup_cmd |=> serial_mode)
        else $error("serial mode not entered");
    a_serial_uses_bit: assert property (@(posedge clk) disable iff (!resetn)
        serial_mode |-> ft_ctrl_on == !apc_q[BIT_SER_FT_OFF])
        else $error("serial mode not using bit 6");
    a_pin_regains: assert property (@(posedge clk) disable iff (!resetn)
        serial_mode && powerdown_cmd |=> !serial_mode ##0 ft_ctrl == ft_sync_q)
        else $error("pin did not regain control");
    a_pin_standalone: assert property (@(posedge clk) disable iff (!resetn)
        !serial_mode |-> ft_ctrl == ft_sync_q)
        else $error("standalone control not from pin");
    a_pin_sync: assert property (@(posedge clk) disable iff (!resetn)
        ft_sync_q == $past(ft_meta_q))
        else $error("pin synchroniser skipped a stage");

    a_volume_field: assert property (@(posedge clk) disable iff (!resetn)
        volume_step == apc_q[VOL_LSB +: VOL_W])
        else $error("volume step wrong");
    a_edit_serial: assert property (@(posedge clk) disable iff (!resetn)
        serial_mode |-> !effect_edit_enable)
        else $error("effect editing enabled in serial mode");
    a_edit_standalone: assert property (@(posedge clk) disable iff (!resetn)
        !serial_mode |-> effect_edit_enable == !apc_q[BIT_EDIT_DIS])
        else $error("effect editing enable wrong");
    a_out_select: assert property (@(posedge clk) disable iff (!resetn)
        analog_out_power_on |-> aux_out_en == apc_q[BIT_OUT_TYPE] && current_out_en != aux_out_en)
        else $error("output type select wrong");
    a_out_power: assert property (@(posedge clk) disable iff (!resetn)
        !analog_out_power_on |-> !current_out_en && !aux_out_en)
        else $error("output enabled while powered down");
    a_power_field: assert property (@(posedge clk) disable iff (!resetn)
        analog_out_power_on != apc_q[BIT_AOUT_OFF])
        else $error("analog output power wrong");
    a_speaker_gate: assert property (@(posedge clk) disable iff (!resetn)
        speaker_driver_en != apc_q[BIT_SPK_DIS])
        else $error("speaker gate wrong");
    a_alert_gate: assert property (@(posedge clk) disable iff (!resetn)
        low_voltage_alert_en != apc_q[BIT_LVA_OFF])
        else $error("low-voltage alert gate wrong");
    a_marker_stop: assert property (@(posedge clk) disable iff (!resetn)
        ranged_stop_at_marker == (ranged_play_cmd && end_marker_stop))
        else $error("ranged stop at marker wrong");
    a_marker_field: assert property (@(posedge clk) disable iff (!resetn)
        end_marker_stop == apc_q[BIT_EOM_STOP])
        else $error("marker stop bit wrong");

    a_play_mix: assert property (@(posedge clk) disable iff (!resetn)
        op == APC_OP_PLAY |-> play_aux_mix == ft_ctrl_on && play_stored)
        else $error("playback mix wrong");
    a_play_only: assert property (@(posedge clk) disable iff (!resetn)
        op != APC_OP_PLAY |-> !play_stored && !play_aux_mix)
        else $error("playback path outside playback");
    a_rec_only: assert property (@(posedge clk) disable iff (!resetn)
        op != APC_OP_REC |-> !rec_from_mic && !rec_from_aux)
        else $error("record path outside recording");
    a_rec_source: assert property (@(posedge clk) disable iff (!resetn)
        op == APC_OP_REC && !apc_q[4] |-> rec_from_mic == ft_ctrl && rec_from_aux == !ft_ctrl)
        else $error("record source wrong");
    a_rec_mix: assert property (@(posedge clk) disable iff (!resetn)
        op == APC_OP_REC && apc_q[BIT_MIX] && ft_ctrl_on |-> rec_from_mic && rec_from_aux)
        else $error("record mix wrong");
    a_rec_mic_only: assert property (@(posedge clk) disable iff (!resetn)
        op == APC_OP_REC && !ft_ctrl_on |-> rec_from_mic && !rec_from_aux)
        else $error("record not from microphone only");
    a_monitor_off: assert property (@(posedge clk) disable iff (!resetn)
        op == APC_OP_REC && !apc_q[3] |-> !ft_mic_to_out && !ft_aux_to_out)
        else $error("monitor active while disabled");
    a_monitor_on: assert property (@(posedge clk) disable iff (!resetn)
        op == APC_OP_REC && apc_q[3] |-> ft_aux_to_out == ft_ctrl_on && ft_mic_to_out == rec_from_mic)
        else $error("monitor does not pass record source");
    a_idle_ft: assert property (@(posedge clk) disable iff (!resetn)
        op == APC_OP_IDLE |-> ft_aux_to_out == ft_ctrl_on && ft_mic_to_out == (ft_ctrl_on && apc_q[4]))
        else $error("idle feed-through wrong");

    c_store: cover property (@(posedge clk) disable iff (!resetn) store_cmd);
    c_serial: cover property (@(posedge clk) disable iff (!resetn) $rose(serial_mode));
    c_mix_rec: cover property (@(posedge clk) disable iff (!resetn) rec_from_mic && rec_from_aux);
    c_reload: cover property (@(posedge clk) disable iff (!resetn) reset_func);
    c_play_mix: cover property (@(posedge clk) disable iff (!resetn) play_aux_mix);

endmodule
`default_nettype wire

// >>> src/apc_path_decode.sv
`timescale 1ns/1ps
`default_nettype none
module apc_path_decode
    import apc_pkg::*;
(
    input wire logic monitor_en,
    input wire logic mix_en,
    input wire logic ft_on,
    input wire logic [1:0] op,
    output logic rec_from_mic,
    output logic rec_from_aux,
    output logic ft_mic_to_out,
    output logic ft_aux_to_out,
    output logic play_stored,
    output logic play_aux_mix
);
    // --------------------------------------------------------------
    // Operational path table
    // --------------------------------------------------------------
    logic is_rec;
    logic is_play;
    logic is_idle;
    logic src_mic;
    logic src_aux;

    always_comb begin
        is_rec = (op == APC_OP_REC);
        is_play = (op == APC_OP_PLAY);
        is_idle = (op == APC_OP_IDLE);
        // Source selection from mix bit and feed-through control
        src_aux = ft_on;
        src_mic = !ft_on || mix_en;
        if (ft_on && !mix_en) begin
            src_mic = 1'b0;
        end
        rec_from_mic = is_rec && src_mic;
        rec_from_aux = is_rec && src_aux;
        // Idle feed-through on control 0, record monitor passes the source
        ft_aux_to_out = src_aux && (is_idle || (is_rec && monitor_en));
        ft_mic_to_out = ft_on ? (mix_en && (is_idle || (is_rec && monitor_en)))
                              : (is_rec && monitor_en);
        play_stored = is_play;
        play_aux_mix = is_play && ft_on;
    end

endmodule
`default_nettype wire

// >>> src/apc_pkg.sv
package apc_pkg;

    localparam int APC_W = 12;
    localparam logic [11:0] APC_FACTORY_DEFAULT = 12'h0440;

    // Field positions
    localparam int VOL_LSB = 0;
    localparam int VOL_W = 3;
    localparam int BIT_MONITOR = 3;
    localparam int BIT_MIX = 4;
    localparam int BIT_EDIT_DIS = 5;
    localparam int BIT_SER_FT_OFF = 6;
    localparam int BIT_OUT_TYPE = 7;
    localparam int BIT_SPK_DIS = 8;
    localparam int BIT_AOUT_OFF = 9;
    localparam int BIT_LVA_OFF = 10;
    localparam int BIT_EOM_STOP = 11;

    // Operation codes
    typedef enum logic [1:0] {
        APC_OP_IDLE = 2'b00,
        APC_OP_REC = 2'b01,
        APC_OP_PLAY = 2'b10
    } apc_op_t;

    // Serial-mode tracker states, one-hot
    typedef enum logic [1:0] {
        APC_ST_STANDALONE = 2'b01,
        APC_ST_SERIAL = 2'b10
    } apc_mode_t;

endpackage

// >>> test/apc_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
module apc_mcu_model (
    input wire logic clk,
    output logic reset_func,
    output logic serial_powerup_cmd,
    output logic powerdown_cmd,
    output logic load_cmd,
    output logic [11:0] load_data,
    output logic store_cmd
);
    initial begin
        {reset_func, serial_powerup_cmd, powerdown_cmd, load_cmd, store_cmd} = 5'b0_0000;
        load_data = 12'h0000;
    end
    // ------------------------------------------------------------
    // Command pulse of one cycle, data inverted once released
    // ------------------------------------------------------------
    task automatic cmd(input int k, input logic [11:0] d);
        @(posedge clk);
        load_cmd <= (k == 0);
        store_cmd <= (k == 1);
        serial_powerup_cmd <= (k == 2);
        powerdown_cmd <= (k == 3);
        reset_func <= (k == 4);
        load_data <= d;
        @(posedge clk);
        {reset_func, serial_powerup_cmd, powerdown_cmd, load_cmd, store_cmd} <= 5'b0_0000;
        load_data <= ~d;
    endtask
endmodule
`default_nettype wire

// >>> test/tb_apc_config_reg.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_apc_config_reg
    import apc_pkg::*;
;
    logic clk = 1'b0, resetn = 1'b0, pin_n = 1'b1, ranged = 1'b0;
    logic reset_func, pu, pd, load_cmd, store_cmd;
    logic [1:0] op = 2'b00;
    logic [11:0] load_data, cfg, nv, v;
    logic ser, edit, cur, aux, spk, apwr, lva, end_marker, rstop, rm, ra, fm, fa, ps, pa;
    logic [2:0] vol;
    int n_mismatch = 0, checks_done = 0;
    localparam int K_LOAD = 0, K_STORE = 1, K_PU = 2, K_PD = 3, K_RST = 4;
    always #2 clk = ~clk;
    apc_config_reg apc_config_reg_inst (.clk(clk), .resetn(resetn), .reset_func(reset_func),
        .feedthrough_pin_n(pin_n), .serial_powerup_cmd(pu), .powerdown_cmd(pd),
        .load_cmd(load_cmd), .load_data(load_data), .store_cmd(store_cmd), .op(op),
        .ranged_play_cmd(ranged), .analog_path_config(cfg), .nonvol_config_bits(nv),
        .serial_mode(ser), .volume_step(vol), .effect_edit_enable(edit),
        .current_out_en(cur), .aux_out_en(aux), .speaker_driver_en(spk),
        .analog_out_power_on(apwr), .low_voltage_alert_en(lva), .end_marker_stop(end_marker),
        .ranged_stop_at_marker(rstop), .rec_from_mic(rm), .rec_from_aux(ra),
        .ft_mic_to_out(fm), .ft_aux_to_out(fa), .play_stored(ps), .play_aux_mix(pa));
    apc_mcu_model apc_mcu_model_inst (.clk(clk), .reset_func(reset_func),
        .serial_powerup_cmd(pu), .powerdown_cmd(pd), .load_cmd(load_cmd),
        .load_data(load_data), .store_cmd(store_cmd));
    // ------------------------------------------------------------
    // Expected path: {rec mic, rec aux, ft mic, ft aux, stored, aux mix}
    // ------------------------------------------------------------
    function automatic logic [5:0] exp_path(input logic [1:0] o, input logic mx, mn, c);
        logic [5:0] e;
        e = 6'b00_0000;
        if (o == APC_OP_IDLE) e = {2'b00, !c & mx, !c, 2'b00};
        if (o == APC_OP_REC) e = {c | mx, !c, mn & (c | mx), mn & !c, 2'b00};
        if (o == APC_OP_PLAY) e = {4'b0000, 1'b1, !c};
        return e;
    endfunction
    task automatic chk_fields(input logic [11:0] x, input logic s);
        #1;
        `CHK(cfg, x)
        `CHK(vol, x[2:0])
        `CHK(edit, !x[5] & !s)
        `CHK({cur, aux}, {!x[9] & !x[7], !x[9] & x[7]})
        `CHK(spk, !x[8])
        `CHK(apwr, !x[9])
        `CHK(lva, !x[10])
        `CHK({end_marker, rstop}, {x[11], x[11] & ranged})
        `CHK(ser, s)
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        logic [11:0] vals [5] = '{12'hFFF, 12'h000, 12'hAAA, 12'h555, 12'h440};
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK({cfg, nv}, {APC_FACTORY_DEFAULT, 12'h440})
        chk_fields(12'h440, 1'b0);
        $display("test reset done");
        ranged <= 1'b1;
        for (int s = 1; s >= 0; s--) begin
            apc_mcu_model_inst.cmd(s ? K_PU : K_PD, 12'h000);
            foreach (vals[j]) begin
                apc_mcu_model_inst.cmd(K_LOAD, vals[j]);
                chk_fields(vals[j], s[0]);
            end
        end
        $display("test fields done");
        apc_mcu_model_inst.cmd(K_LOAD, 12'h3C5);
        apc_mcu_model_inst.cmd(K_STORE, 12'h000);
        #1;
        `CHK(nv, 12'h3C5)
        apc_mcu_model_inst.cmd(K_LOAD, 12'h00F);
        apc_mcu_model_inst.cmd(K_RST, 12'h000);
        #1;
        `CHK(cfg, 12'h3C5)
        ranged <= 1'b0;
        apc_mcu_model_inst.cmd(K_LOAD, 12'h800);
        chk_fields(12'h800, 1'b0);
        $display("test store done");
        for (int i = 0; i < 16; i++) begin
            if (i == 8) apc_mcu_model_inst.cmd(K_PU, 12'h000);
            v = 12'h000;
            v[BIT_MONITOR] = i[0];
            v[BIT_MIX] = i[1];
            v[BIT_SER_FT_OFF] = i[3] ? i[2] : !i[2];
            apc_mcu_model_inst.cmd(K_LOAD, v);
            @(posedge clk);
            pin_n <= i[3] ? !i[2] : i[2];
            for (int o = 0; o < 4; o++) begin
                op <= o[1:0];
                repeat (4) @(posedge clk);
                #1;
                `CHK({rm, ra, fm, fa, ps, pa}, exp_path(o[1:0], i[1], i[0], i[2]))
            end
        end
        $display("test paths done");
        give_verdict();
    end
endmodule
`default_nettype wire
